// >>> common/alu_params.svh
// Purpose: named constants for the carry, rotate, move and add datapath
// Assumes: included by bare name from each design file
// Notes: flag positions follow the processor status word order
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH
`define WORD_W 16
`define FLAG_W 4
`define AXI_ADDR_W 8
`define AXI_DATA_W 32
`define AXI_STRB_W 4
`define REG_CTRL 8'h00
`define REG_OPCODE 8'h04
`define REG_SRC 8'h08
`define REG_DST 8'h0C
`define REG_FLAGS 8'h10
`define REG_RESULT 8'h14
`define REG_STATUS 8'h18
`define CTRL_START 0
`define CTRL_DST_REG 1
`define STATUS_BAD_OP 0
`define STATUS_BUSY 1
`define FLAG_C 0
`define FLAG_V 1
`define FLAG_Z 2
`define FLAG_N 3
`define BYTE_BIT 15
`define BYTE_TOP 7
`define WORD_TOP 15
`define OPC_CLASS_MASK 16'h7FC0
`define OPC_WORD_MASK 16'hFFC0
`define OPC_DOUBLE_MASK 16'h7000
`define OPC_SUM_MASK 16'hF000
`define OPC_CARRY_ADD 16'h0B40
`define OPC_BORROW_SUB 16'h0B80
`define OPC_ROT_RIGHT 16'h0C00
`define OPC_ROT_LEFT 16'h0C40
`define OPC_SIGN_EXT 16'h0DC0
`define OPC_EXCHANGE 16'h00C0
`define OPC_COPY 16'h1000
`define OPC_SUM 16'h6000
`define WORD_MASK 16'hFFFF
`define BYTE_MASK 16'h00FF
`define WORD_MAX_POS 16'h7FFF
`define BYTE_MAX_POS 16'h007F
`define WORD_MIN_NEG 16'h8000
`define BYTE_MIN_NEG 16'h0080
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> common/alu_pkg.sv
// Purpose: shared types of the datapath
// Assumes: nothing beyond the tool's SystemVerilog support
// Notes: operation classes only, opcodes live in the params header
`default_nettype none
package alu_pkg;
    typedef enum logic [3:0] {
        NO_OP, CARRY_IN_SUM_OP, BORROW_IN_DIFF_OP, SIGN_EXTEND_OP, ROTATE_LEFT_OP,
        ROTATE_RIGHT_OP, BYTE_EXCHANGE_OP, COPY_OP, SUM_OP
    } alu_op_type;
endpackage
`default_nettype wire

// >>> hdl/opcode_decode.sv
// Purpose: classify an instruction word into one datapath operation
// Assumes: opcode is stable for the cycle it is used
// Notes: unknown words give no_op, which keeps the flags and passes the destination word to the result
`timescale 1ns/1ps
`default_nettype none
`include "alu_params.svh"
module opcode_decode
    import alu_pkg::*;
(
    input wire logic [`WORD_W-1:0] opcode,
    output alu_op_type opSel,
    output logic byteMode
);
    always_comb begin
        byteMode = opcode[`BYTE_BIT]; // RQ16
        if ((opcode & `OPC_CLASS_MASK) == `OPC_CARRY_ADD) begin
            opSel = CARRY_IN_SUM_OP;
        end else if ((opcode & `OPC_CLASS_MASK) == `OPC_BORROW_SUB) begin
            opSel = BORROW_IN_DIFF_OP;
        end else if ((opcode & `OPC_CLASS_MASK) == `OPC_ROT_LEFT) begin
            opSel = ROTATE_LEFT_OP;
        end else if ((opcode & `OPC_CLASS_MASK) == `OPC_ROT_RIGHT) begin
            opSel = ROTATE_RIGHT_OP;
        end else if ((opcode & `OPC_WORD_MASK) == `OPC_SIGN_EXT) begin
            opSel = SIGN_EXTEND_OP;
        end else if ((opcode & `OPC_WORD_MASK) == `OPC_EXCHANGE) begin
            opSel = BYTE_EXCHANGE_OP;
        end else if ((opcode & `OPC_DOUBLE_MASK) == `OPC_COPY) begin
            opSel = COPY_OP;
        end else if ((opcode & `OPC_SUM_MASK) == `OPC_SUM) begin
            opSel = SUM_OP;
        end else begin
            opSel = NO_OP;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/flag_alu.sv
// Purpose: result word and new condition flags for one operation
// Assumes: byte operands sit in the low byte of the operand words
// Notes: combinational, the caller registers everything
`timescale 1ns/1ps
`default_nettype none
`include "alu_params.svh"
module flag_alu
    import alu_pkg::*;
(
    input wire alu_op_type opSel,
    input wire logic byteMode,
    input wire logic dstIsReg,
    input wire logic [`WORD_W-1:0] srcOperand,
    input wire logic [`WORD_W-1:0] dstOperand,
    input wire logic [`FLAG_W-1:0] flagsIn,
    output logic [`WORD_W-1:0] result,
    output logic [`FLAG_W-1:0] flagsOut
);
    logic [`WORD_W-1:0] mask, maxPos, minNeg, dm, r, cinWord;
    logic [`WORD_W:0] sum;
    logic cin, topR;
    always_comb begin
        mask = byteMode ? `BYTE_MASK : `WORD_MASK;
        maxPos = byteMode ? `BYTE_MAX_POS : `WORD_MAX_POS;
        minNeg = byteMode ? `BYTE_MIN_NEG : `WORD_MIN_NEG;
        dm = dstOperand & mask;
        cin = flagsIn[`FLAG_C];
        cinWord = {15'h0, cin};
        sum = {1'h0, srcOperand} + {1'h0, dstOperand};
        r = dm;
        flagsOut = flagsIn; // RQ17
        case (opSel)
            CARRY_IN_SUM_OP: begin
                r = (dm + cinWord) & mask; // RQ1
                flagsOut[`FLAG_V] = (dm == maxPos) & cin; // RQ1
                flagsOut[`FLAG_C] = (dm == mask) & cin; // RQ1
            end
            BORROW_IN_DIFF_OP: begin
                r = (dm - cinWord) & mask; // RQ2
                flagsOut[`FLAG_V] = (dm == minNeg); // RQ2
                flagsOut[`FLAG_C] = (dm == 16'h0) & cin; // RQ2
            end
            SIGN_EXTEND_OP: begin
                r = flagsIn[`FLAG_N] ? `WORD_MASK : 16'h0; // RQ3
                flagsOut[`FLAG_V] = 1'h0; // RQ4
                flagsOut[`FLAG_Z] = ~flagsIn[`FLAG_N]; // RQ4
            end
            ROTATE_LEFT_OP: begin
                r = ((dm << 1) | cinWord) & mask; // RQ5 RQ6
                flagsOut[`FLAG_C] = byteMode ? dm[`BYTE_TOP] : dm[`WORD_TOP]; // RQ6
            end
            ROTATE_RIGHT_OP: begin
                r = (dm >> 1) | (byteMode ? {8'h0, cin, 7'h0} : {cin, 15'h0}); // RQ5 RQ7
                flagsOut[`FLAG_C] = dm[0]; // RQ7
            end
            BYTE_EXCHANGE_OP: begin
                r = {dstOperand[7:0], dstOperand[15:8]}; // RQ9
                flagsOut[`FLAG_V] = 1'h0; // RQ10
                flagsOut[`FLAG_C] = 1'h0; // RQ10
            end
            COPY_OP: begin
                r = srcOperand & mask; // RQ11
                flagsOut[`FLAG_V] = 1'h0; // RQ11
            end
            SUM_OP: begin
                r = sum[`WORD_W-1:0]; // RQ13
                flagsOut[`FLAG_V] = (srcOperand[`WORD_TOP] == dstOperand[`WORD_TOP])
                    & (r[`WORD_TOP] != srcOperand[`WORD_TOP]); // RQ14
                flagsOut[`FLAG_C] = sum[`WORD_W]; // RQ15
            end
            default: begin
                r = dstOperand;
            end
        endcase
        topR = byteMode ? r[`BYTE_TOP] : r[`WORD_TOP];
        if (opSel == BYTE_EXCHANGE_OP) begin
            flagsOut[`FLAG_N] = r[`BYTE_TOP]; // RQ10
            flagsOut[`FLAG_Z] = (r[7:0] == 8'h0); // RQ10
        end else if (opSel != NO_OP && opSel != SIGN_EXTEND_OP) begin
            flagsOut[`FLAG_N] = topR; // RQ8 RQ11 RQ13 RQ16
            flagsOut[`FLAG_Z] = (r == 16'h0); // RQ8 RQ11 RQ13 RQ16
        end
        if (opSel == ROTATE_LEFT_OP || opSel == ROTATE_RIGHT_OP) begin
            flagsOut[`FLAG_V] = flagsOut[`FLAG_N] ^ flagsOut[`FLAG_C]; // RQ8
        end
        // word-only operations write the whole word
        if (opSel == NO_OP || opSel == SIGN_EXTEND_OP || opSel == BYTE_EXCHANGE_OP
                || opSel == SUM_OP || !byteMode) begin
            result = r;
        end else if (opSel == COPY_OP && dstIsReg) begin
            result = {{8{r[`BYTE_TOP]}}, r[7:0]}; // RQ12
        end else begin
            result = {dstOperand[15:8], r[7:0]}; // RQ16
        end
    end
endmodule
`default_nettype wire

// >>> hdl/alu_top.sv
// Purpose: carry, rotate, move and add execution unit behind AXI4-Lite
// Assumes: one write and one read outstanding at most, 100 MHz clock
// Notes: a start write runs the operation in the cycle its write response is raised
//
// What this block does
// RQ1 - add-carry adds C; V only at 077777 with C, C only at 177777 with C
// RQ2 - subtract-carry takes C away; V at 100000, C when zero with C set
// RQ3 - sign-extend writes all ones if N set, else all zeros
// RQ4 - sign-extend keeps N and C, clears V, sets Z when N clear
// RQ5 - rotates treat destination plus C as one 17-bit ring, 9-bit in byte form
// RQ6 - rotate-left: top bit into C, old C into bit 0
// RQ7 - rotate-right: bit 0 into C, old C into the top bit
// RQ8 - after rotates N is top bit, Z on zero, V is N xor C
// RQ9 - byte-exchange swaps the two bytes of a word destination only
// RQ10 - byte-exchange: N from bit 7, Z from low byte, V and C cleared
// RQ11 - copy moves source unchanged; N, Z from it, V cleared, C kept
// RQ12 - byte copy to a register sign-extends bit 7 into the upper byte
// RQ13 - add stores the two's complement sum; N and Z follow it
// RQ14 - add sets V when like-signed operands give an opposite-signed sum
// RQ15 - add sets C on carry out of the most significant bit
// RQ16 - opcode bit 15 selects byte form; flags from bit 7, one byte written
// RQ17 - untouched flags keep value; all flags change with the result write
`timescale 1ns/1ps
`default_nettype none
`include "alu_params.svh"
module alu_top
    import alu_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [`AXI_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [`AXI_DATA_W-1:0] wdata,
    input wire logic [`AXI_STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`AXI_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [`AXI_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    logic [`WORD_W-1:0] opcode_reg, srcOperand_reg, dstOperand_reg, result_reg;
    logic [`FLAG_W-1:0] flags_reg;
    logic dstIsReg_reg, execPend_reg, badOpcode_reg;
    logic awHeld_reg, wHeld_reg;
    logic [`AXI_ADDR_W-1:0] awAddr_reg;
    logic [`AXI_DATA_W-1:0] wData_reg;
    logic [`AXI_STRB_W-1:0] wStrb_reg;
    logic awTake, wTake, arTake, commit, awHeldNext, wHeldNext, wrMapped;
    logic [`AXI_DATA_W-1:0] readWord;
    logic readMapped;
    alu_op_type opSel;
    logic byteMode;
    logic [`WORD_W-1:0] aluResult;
    logic [`FLAG_W-1:0] aluFlags;
    logic [`WORD_W:0] sumCheck;

    function automatic logic [`WORD_W-1:0] merge16(
        input logic [`WORD_W-1:0] old,
        input logic [`AXI_DATA_W-1:0] data,
        input logic [`AXI_STRB_W-1:0] strb
    );
        merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction

    opcode_decode decoder (
        .opcode(opcode_reg),
        .opSel(opSel),
        .byteMode(byteMode)
    );

    flag_alu datapath (
        .opSel(opSel),
        .byteMode(byteMode),
        .dstIsReg(dstIsReg_reg),
        .srcOperand(srcOperand_reg),
        .dstOperand(dstOperand_reg),
        .flagsIn(flags_reg),
        .result(aluResult),
        .flagsOut(aluFlags)
    );

    // write channel: address and data are held separately, either may come first
    assign awTake = awvalid & awready;
    assign wTake = wvalid & wready;
    assign commit = awHeld_reg & wHeld_reg & ~bvalid;
    assign awHeldNext = (awHeld_reg | awTake) & ~commit;
    assign wHeldNext = (wHeld_reg | wTake) & ~commit;
    assign wrMapped = (awAddr_reg == `REG_CTRL) || (awAddr_reg == `REG_OPCODE)
        || (awAddr_reg == `REG_SRC) || (awAddr_reg == `REG_DST)
        || (awAddr_reg == `REG_FLAGS) || (awAddr_reg == `REG_RESULT)
        || (awAddr_reg == `REG_STATUS);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            awHeld_reg <= 1'h0;
            wHeld_reg <= 1'h0;
            awready <= 1'h1;
            wready <= 1'h1;
        end else begin
            awHeld_reg <= awHeldNext;
            wHeld_reg <= wHeldNext;
            awready <= ~awHeldNext;
            wready <= ~wHeldNext;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            awAddr_reg <= `AXI_ADDR_W'h0;
            wData_reg <= `AXI_DATA_W'h0;
            wStrb_reg <= `AXI_STRB_W'h0;
        end else begin
            if (awTake) begin
                awAddr_reg <= awaddr;
            end
            if (wTake) begin
                wData_reg <= wdata;
                wStrb_reg <= wstrb;
            end
        end
    end

    // response follows both halves; unmapped offsets answer slverr
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bvalid <= 1'h0;
            bresp <= `RESP_OKAY;
        end else if (commit) begin
            bvalid <= 1'h1;
            bresp <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'h0;
        end
    end

    // operand and control registers; read-only offsets ignore writes
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            opcode_reg <= `WORD_W'h0;
            srcOperand_reg <= `WORD_W'h0;
            dstOperand_reg <= `WORD_W'h0;
            dstIsReg_reg <= 1'h0;
        end else if (commit) begin
            if (awAddr_reg == `REG_OPCODE) begin
                opcode_reg <= merge16(opcode_reg, wData_reg, wStrb_reg);
            end
            if (awAddr_reg == `REG_SRC) begin
                srcOperand_reg <= merge16(srcOperand_reg, wData_reg, wStrb_reg);
            end
            if (awAddr_reg == `REG_DST) begin
                dstOperand_reg <= merge16(dstOperand_reg, wData_reg, wStrb_reg);
            end
            if (awAddr_reg == `REG_CTRL && wStrb_reg[0]) begin
                dstIsReg_reg <= wData_reg[`CTRL_DST_REG];
            end
        end
    end

    // start is a pulse: the operation runs on the cycle after the write
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            execPend_reg <= 1'h0;
        end else begin
            execPend_reg <= commit && (awAddr_reg == `REG_CTRL) && wStrb_reg[0]
                && wData_reg[`CTRL_START];
        end
    end

    // result and all flags update on the same edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            result_reg <= `WORD_W'h0;
            badOpcode_reg <= 1'h0;
        end else if (execPend_reg) begin
            result_reg <= aluResult; // RQ17
            badOpcode_reg <= (opSel == NO_OP);
        end
    end

    // execution wins over a software write; the bus keeps them apart
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flags_reg <= `FLAG_W'h0;
        end else if (execPend_reg) begin
            flags_reg <= aluFlags; // RQ17
        end else if (commit && awAddr_reg == `REG_FLAGS && wStrb_reg[0]) begin
            flags_reg <= wData_reg[`FLAG_W-1:0];
        end
    end

    // read side
    assign arTake = arvalid & arready;

    always_comb begin
        readWord = `AXI_DATA_W'h0;
        readMapped = 1'h1;
        case (araddr)
            `REG_CTRL: readWord[`CTRL_DST_REG] = dstIsReg_reg;
            `REG_OPCODE: readWord[`WORD_W-1:0] = opcode_reg;
            `REG_SRC: readWord[`WORD_W-1:0] = srcOperand_reg;
            `REG_DST: readWord[`WORD_W-1:0] = dstOperand_reg;
            `REG_FLAGS: readWord[`FLAG_W-1:0] = flags_reg;
            `REG_RESULT: readWord[`WORD_W-1:0] = result_reg;
            `REG_STATUS: begin
                readWord[`STATUS_BAD_OP] = badOpcode_reg;
                readWord[`STATUS_BUSY] = execPend_reg;
            end
            default: readMapped = 1'h0;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'h1;
            rvalid <= 1'h0;
            rdata <= `AXI_DATA_W'h0;
            rresp <= `RESP_OKAY;
        end else if (arTake) begin
            arready <= 1'h0;
            rvalid <= 1'h1;
            rdata <= readWord;
            rresp <= readMapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'h1;
            rvalid <= 1'h0;
        end
    end

    // independent adder for the sum check
    assign sumCheck = {1'h0, srcOperand_reg} + {1'h0, dstOperand_reg};

    AST_CARRY_ADD_FLAGS: // RQ1
    assert property (@(posedge clock) disable iff (!nrst)
        execPend_reg && opSel == CARRY_IN_SUM_OP && !byteMode |=>
            result_reg == $past(dstOperand_reg) + {15'h0, $past(flags_reg[`FLAG_C])}
            && flags_reg[`FLAG_V] == ($past(dstOperand_reg) == `WORD_MAX_POS
                && $past(flags_reg[`FLAG_C]))
            && flags_reg[`FLAG_C] == ($past(dstOperand_reg) == `WORD_MASK
                && $past(flags_reg[`FLAG_C])))
        else $error("add-carry result or flags wrong");

    AST_BORROW_FLAGS: // RQ2
    assert property (@(posedge clock) disable iff (!nrst)
        execPend_reg && opSel == BORROW_IN_DIFF_OP && !byteMode |=>
            flags_reg[`FLAG_V] == ($past(dstOperand_reg) == `WORD_MIN_NEG)
            && flags_reg[`FLAG_C] == ($past(dstOperand_reg) == 16'h0
                && $past(flags_reg[`FLAG_C])))
        else $error("subtract-carry flags wrong");

    AST_SIGN_EXTEND: // RQ3
    assert property (@(posedge clock) disable iff (!nrst)
        execPend_reg && opSel == SIGN_EXTEND_OP |=>
            result_reg == ($past(flags_reg[`FLAG_N]) ? `WORD_MASK : 16'h0)
            && flags_reg[`FLAG_N] == $past(flags_reg[`FLAG_N])
            && flags_reg[`FLAG_C] == $past(flags_reg[`FLAG_C])
            && !flags_reg[`FLAG_V] && flags_reg[`FLAG_Z] == !flags_reg[`FLAG_N])
        else $error("sign-extend result or flags wrong");

    AST_ROTATE_LEFT: // RQ6
    assert property (@(posedge clock) disable iff (!nrst)
        execPend_reg && opSel == ROTATE_LEFT_OP && !byteMode |=>
            {flags_reg[`FLAG_C], result_reg}
                == {$past(dstOperand_reg), $past(flags_reg[`FLAG_C])})
        else $error("rotate-left ring wrong");

    AST_ROTATE_RIGHT: // RQ7
    assert property (@(posedge clock) disable iff (!nrst)
        execPend_reg && opSel == ROTATE_RIGHT_OP && !byteMode |=>
            {result_reg, flags_reg[`FLAG_C]}
                == {$past(flags_reg[`FLAG_C]), $past(dstOperand_reg)})
        else $error("rotate-right ring wrong");

    AST_ROTATE_V: // RQ8
    assert property (@(posedge clock) disable iff (!nrst)
        execPend_reg && (opSel == ROTATE_LEFT_OP || opSel == ROTATE_RIGHT_OP) && !byteMode
        |=> flags_reg[`FLAG_V] == (flags_reg[`FLAG_N] ^ flags_reg[`FLAG_C])
            && flags_reg[`FLAG_N] == result_reg[`WORD_TOP])
        else $error("rotate overflow not n xor c");

    AST_EXCHANGE: // RQ10
    assert property (@(posedge clock) disable iff (!nrst)
        execPend_reg && opSel == BYTE_EXCHANGE_OP |=>
            result_reg == {$past(dstOperand_reg[7:0]), $past(dstOperand_reg[15:8])}
            && flags_reg[`FLAG_N] == result_reg[`BYTE_TOP]
            && !flags_reg[`FLAG_V] && !flags_reg[`FLAG_C])
        else $error("byte-exchange wrong");

    AST_COPY_BYTE_REG: // RQ12
    assert property (@(posedge clock) disable iff (!nrst)
        execPend_reg && opSel == COPY_OP && byteMode && dstIsReg_reg |=>
            result_reg == {{8{$past(srcOperand_reg[`BYTE_TOP])}}, $past(srcOperand_reg[7:0])}
            && flags_reg[`FLAG_C] == $past(flags_reg[`FLAG_C]))
        else $error("byte copy to register not sign-extended");

    AST_SUM_CARRY: // RQ15
    assert property (@(posedge clock) disable iff (!nrst)
        execPend_reg && opSel == SUM_OP |=>
            {flags_reg[`FLAG_C], result_reg} == $past(sumCheck))
        else $error("sum or carry wrong");

    AST_SUM_OVERFLOW: // RQ14
    assert property (@(posedge clock) disable iff (!nrst)
        execPend_reg && opSel == SUM_OP && srcOperand_reg[`WORD_TOP] != dstOperand_reg[`WORD_TOP]
        |=> !flags_reg[`FLAG_V])
        else $error("sum overflow on unlike signs");

    AST_FLAGS_HOLD: // RQ17
    assert property (@(posedge clock) disable iff (!nrst)
        !execPend_reg && !(commit && awAddr_reg == `REG_FLAGS) |=> $stable(flags_reg)
            && $stable(result_reg))
        else $error("flags or result moved without an operation");

    AST_WRITE_RESPONSE:
    assert property (@(posedge clock) disable iff (!nrst)
        commit |=> bvalid && !awHeld_reg && !wHeld_reg)
        else $error("write response not raised after commit");
endmodule
`default_nettype wire

// >>> sim/decode_ctrl_model.sv
// Purpose: processor-side master for AXI4-Lite register cycles
// Assumes: one write and one read at most in flight
// Notes: hung rises when a handshake wait runs out
`timescale 1ns/1ps
`default_nettype none
`include "alu_params.svh"
module decode_ctrl_model (
    input wire logic clock,
    output logic [`AXI_ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [`AXI_DATA_W-1:0] wdata,
    output logic [`AXI_STRB_W-1:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [`AXI_ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [`AXI_DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    output logic hung
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, hung} = '0;
    end
    // released payload is scrambled so nothing leans on a stale value
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        {awvalid, wvalid, bready} <= 3'h7;
        for (i = 0; i < 64; i++) begin
            @(posedge clock);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
            if (bvalid && bready) break;
        end
        bready <= 1'b0;
        if (i == 64) hung <= 1'b1;
    endtask
    task automatic rd(input logic [7:0] a);
        int i;
        @(posedge clock);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (i = 0; i < 64; i++) begin
            @(posedge clock);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~araddr;
            end
            if (rvalid && rready) break;
        end
        rready <= 1'b0;
        if (i == 64) hung <= 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Purpose: self-checking bench for the datapath unit
// Assumes: register map and opcodes of the params header
// Notes: a monitor compares each answer with the oldest note
`timescale 1ns/1ps
`default_nettype none
`include "alu_params.svh"
module testbench;
    logic clock, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, hung;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [33:0] expQ[$];
    logic [1:0] bQ[$];
    string nameQ[$];
    logic [19:0] lastE;
    int miscompares = 0, nCompared = 0, i;
    logic [15:0] opc [8] = '{`OPC_CARRY_ADD, `OPC_BORROW_SUB, `OPC_ROT_RIGHT, `OPC_ROT_LEFT,
        `OPC_SIGN_EXT, `OPC_EXCHANGE, `OPC_COPY, `OPC_SUM};
    alu_top u_dut (.clock(clock), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    decode_ctrl_model u_master (.clock(clock), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .hung(hung));
    always #5 clock = ~clock;
    task automatic check(input string nm, input logic [33:0] e, input logic [33:0] g);
        nCompared++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clock) begin
        if (rvalid === 1'b1 && rready === 1'b1) check(nameQ.pop_front(), expQ.pop_front(),
            {rresp, rdata});
        if (bvalid === 1'b1 && bready === 1'b1) check("bresp", 34'(bQ.pop_front()), 34'(bresp));
        if (hung === 1'b1) begin
            miscompares++;
            tally_and_finish();
        end
    end
    // returns flags N Z V C above the 16-bit result word
    function automatic logic [19:0] model(int k, logic b, logic [15:0] s, d, logic [3:0] f,
        logic dr);
        logic [15:0] m, x, r;
        logic n, z, v, c;
        int t;
        t = b ? 7 : 15;
        m = b ? `BYTE_MASK : `WORD_MASK;
        x = d & m;
        {n, z, v, c} = f;
        case (k)
            0: begin r = (x + c) & m; v = x == (m >> 1) && c; c = x == m && c; end
            1: begin r = (x - c) & m; v = x == (m >> 1) + 16'h1; c = x == 16'h0 && c; end
            2: begin r = (x >> 1) | (16'(c) << t); c = x[0]; end
            3: begin r = ((x << 1) | 16'(c)) & m; c = x[t]; end
            4: begin r = {16{n}}; z = !n; v = 1'b0; end
            5: begin r = {d[7:0], d[15:8]}; t = 7; {v, c} = 2'b00; end
            6: begin r = s & m; v = 1'b0; end
            default: begin {c, r} = 17'(s) + 17'(d); v = s[15] == d[15] && r[15] != s[15]; end
        endcase
        if (k != 4) {n, z} = {r[t], t == 7 ? r[7:0] == 8'h0 : r == 16'h0};
        if (k == 2 || k == 3) v = n ^ c;
        if (b) r = (k == 6 && dr) ? {{8{r[7]}}, r[7:0]} : {d[15:8], r[7:0]};
        return {n, z, v, c, r};
    endfunction
    task automatic expect_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        bQ.push_back(e);
        u_master.wr(a, d);
    endtask
    task automatic expect_rd(input logic [7:0] a, input string nm, input logic [33:0] e);
        expQ.push_back(e);
        nameQ.push_back(nm);
        u_master.rd(a);
    endtask
    task automatic run_op(input int k, input logic b, input logic [15:0] s, d,
        input logic [3:0] f, input logic dr);
        logic [15:0] op;
        op = opc[k] | {b, 15'h0} | (16'($urandom) & (k > 5 ? 16'h0FFF : 16'h003F));
        lastE = model(k, b, s, d, f, dr);
        expect_wr(`REG_SRC, {16'h0, s}, `RESP_OKAY);
        expect_wr(`REG_DST, {16'h0, d}, `RESP_OKAY);
        expect_wr(`REG_FLAGS, {28'h0, f}, `RESP_OKAY);
        expect_wr(`REG_OPCODE, {16'h0, op}, `RESP_OKAY);
        expect_wr(`REG_CTRL, {30'h0, dr, 1'b1}, `RESP_OKAY);
        expect_rd(`REG_RESULT, "result", {`RESP_OKAY, 16'h0, lastE[15:0]});
        expect_rd(`REG_FLAGS, "flags", {`RESP_OKAY, 28'h0, lastE[19:16]});
    endtask
    initial begin
        {clock, nrst} = 2'b00;
        void'($urandom(99576));
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        run_op(0, 0, 16'h1234, 16'h7FFF, 4'h1, 0);
        run_op(0, 0, 16'h0000, 16'hFFFF, 4'h1, 0);
        run_op(0, 1, 16'h0000, 16'hA57F, 4'h1, 1);
        run_op(1, 0, 16'h0000, 16'h8000, 4'h0, 0);
        run_op(1, 0, 16'h0000, 16'h0000, 4'h1, 0);
        run_op(4, 0, 16'h0000, 16'h1234, 4'h9, 0);
        run_op(4, 0, 16'h0000, 16'h5A5A, 4'h7, 0);
        run_op(3, 0, 16'h0000, 16'h8000, 4'h0, 0);
        run_op(2, 0, 16'h0000, 16'h0001, 4'h1, 0);
        run_op(3, 1, 16'h0000, 16'hC380, 4'h0, 0);
        run_op(5, 0, 16'h0000, 16'h7FFF, 4'hF, 0);
        run_op(6, 0, 16'h8000, 16'h1111, 4'h3, 0);
        run_op(6, 1, 16'h0080, 16'h1111, 4'h0, 1);
        run_op(6, 1, 16'hFF80, 16'h3311, 4'h0, 0);
        run_op(7, 0, 16'h7FFF, 16'h0001, 4'h0, 0);
        run_op(7, 0, 16'hFFFF, 16'h0001, 4'h0, 0);
        $display("test corner_ops done");
        for (i = 0; i < 60; i++) begin
            automatic int k = $urandom_range(7);
            run_op(k, $urandom & (k < 4 | k == 6), $urandom, $urandom, $urandom, $urandom);
        end
        $display("test random_ops done");
        expect_wr(8'h40, 32'h0000FFFF, `RESP_SLVERR);
        expect_rd(8'h40, "unmapped", {`RESP_SLVERR, 32'h0});
        expect_wr(`REG_RESULT, 32'h0000A5A5, `RESP_OKAY);
        expect_rd(`REG_RESULT, "result_ro", {`RESP_OKAY, 16'h0, lastE[15:0]});
        expect_wr(`REG_OPCODE, 32'hFFFF, `RESP_OKAY);
        expect_wr(`REG_CTRL, 32'h1, `RESP_OKAY);
        expect_rd(`REG_STATUS, "status", {`RESP_OKAY, 32'h1});
        repeat (4) @(posedge clock);
        $display("test bus_map done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
